/* hw/rlc_pkg.sv */
// Package: register map, field layout and constants of the retry/compare-swap slice
// Notes on behaviour
// - The three-bit dual-phase second bound at bits 31-29 of the retry register reads as zero.
// - The thirteen-bit dual-phase cycle bound at bits 28-16 of the retry register reads as zero.
// - Bits 15-12 of the retry register are reserved and read as zero.
// - The physical response unit retries a response up to the count in bits 11-8 on busy or data error.
// - The transmit response unit retries a response up to the count in bits 7-4 on busy or data error.
// - The transmit request unit retries a request up to the count in bits 3-0 on busy or data error.
// - The new-value register holds the word stored into the resource when a compare-swap matches.
// - The expected-value register holds the word compared with the selected resource.
// - The device sets the done flag in bit 31 of the control register when a compare-swap ends.
// - A write to the control register clears the done flag, except in a cycle where a compare-swap ends, when done stays set.
// - Control bits 1-0 select the resource: 0 manager id, 1 bandwidth, 2 channels high, 3 low.
// - Control bits 30-2 are reserved and read as zero.
package rlc_pkg;
   localparam logic [7:0]  RETRY_OFS       = 8'h08;
   localparam logic [7:0]  NEW_VALUE_OFS   = 8'h0c;
   localparam logic [7:0]  EXPECTED_OFS    = 8'h10;
   localparam logic [7:0]  CONTROL_OFS     = 8'h14;
   localparam logic [7:0]  IRQ_STATUS_OFS  = 8'h80;
   localparam logic [7:0]  IRQ_MASK_OFS    = 8'h84;
   localparam logic [7:0]  RESOURCE_OFS    = 8'h88;

   localparam int          RETRY_FIELD_W   = 4;
   localparam logic [11:0] RETRY_RW_MASK   = 12'hfff;
   localparam logic [31:0] RETRY_RESET     = 32'h0000_0000;
   localparam int          DONE_BIT        = 31;
   localparam logic        DONE_RESET      = 1'b1;
   localparam logic [1:0]  SELECT_RESET    = 2'h0;

   // Unit index: 0 request, 1 response, 2 physical response
   localparam int          UNITS           = 3;
   localparam int          IRQ_W           = 4;
   localparam int          IRQ_CS_DONE_BIT = 0;

   // Resource selector codes and values after reset
   localparam logic [1:0]  SEL_MANAGER_ID  = 2'h0;
   localparam logic [1:0]  SEL_BANDWIDTH   = 2'h1;
   localparam logic [1:0]  SEL_CHAN_HI     = 2'h2;
   localparam logic [1:0]  SEL_CHAN_LO     = 2'h3;
   localparam logic [31:0] MANAGER_RESET   = 32'h0000_003f;
   localparam logic [31:0] BANDWIDTH_RESET = 32'h0000_1333;
   localparam logic [31:0] CHAN_RESET      = 32'hffff_ffff;

   // Acknowledge codes that call for a retry
   localparam logic [3:0]  ACK_BUSY_X      = 4'h4;
   localparam logic [3:0]  ACK_BUSY_A      = 4'h5;
   localparam logic [3:0]  ACK_BUSY_B      = 4'h6;
   localparam logic [3:0]  ACK_DATA_ERROR  = 4'hd;

   localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

   typedef enum logic [1:0] {
      CS_IDLE = 2'b01,
      CS_SWAP = 2'b10
   } rlc_cs_state_t;
endpackage : rlc_pkg

/* hw/rlc_retry_unit.sv */
// Retry counter of one asynchronous transmit unit
`timescale 1ns/10ps
`default_nettype none
module rlc_retry_unit (
   input  wire logic       sys_clk,        // System clock
   input  wire logic       rst_n,          // Asynchronous reset, active low
   input  wire logic [3:0] retry_limit,    // Retries allowed for one packet
   input  wire logic       ack_valid,      // One attempt answered
   input  wire logic [3:0] ack_code,       // Acknowledge of that attempt
   output logic            retry_r,        // Pulse: send the packet again
   output logic            complete_r,     // Pulse: packet finished
   output logic [3:0]      status_r,       // Last acknowledge of the packet
   output logic            exhausted_r     // Pulse: finished after using all retries
);
   logic [3:0] count_r;
   logic       wants_retry;

   always_comb begin
      wants_retry = (ack_code == rlc_pkg::ACK_BUSY_X) || (ack_code == rlc_pkg::ACK_BUSY_A) ||
                    (ack_code == rlc_pkg::ACK_BUSY_B) || (ack_code == rlc_pkg::ACK_DATA_ERROR);
   end

   // Attempt counter restarts with every finished packet
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= 4'h0;
      end else if (ack_valid) begin
         if (wants_retry && count_r < retry_limit) begin
            count_r <= count_r + 4'h1;
         end else begin
            count_r <= 4'h0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         retry_r     <= 1'b0;
         complete_r  <= 1'b0;
         exhausted_r <= 1'b0;
         status_r    <= 4'h0;
      end else begin
         retry_r     <= ack_valid && wants_retry && count_r < retry_limit;
         complete_r  <= ack_valid && !(wants_retry && count_r < retry_limit);
         exhausted_r <= ack_valid && wants_retry && count_r >= retry_limit;
         if (ack_valid) begin
            status_r <= ack_code;
         end
      end
   end
endmodule : rlc_retry_unit
`default_nettype wire

/* hw/rlc_top.sv */
// AHB-Lite register slice: transmit retry limits and bus-management compare-swap
`timescale 1ns/10ps
`default_nettype none
module rlc_top (
   input  wire logic        sys_clk,         // System clock, 200 MHz
   input  wire logic        rst_n,           // Asynchronous reset, active low
   input  wire logic        hsel,            // AHB slave select
   input  wire logic [31:0] haddr,           // AHB address
   input  wire logic [1:0]  htrans,          // AHB transfer type
   input  wire logic        hwrite,          // AHB write
   input  wire logic [2:0]  hsize,           // AHB size, word only
   input  wire logic [31:0] hwdata,          // AHB write data
   input  wire logic        hready,          // AHB bus ready
   output logic             hreadyout,       // AHB slave ready
   output logic [31:0]      hrdata,          // AHB read data
   output logic             hresp,           // AHB response, always OKAY
   input  wire logic [2:0]  tx_ack_valid,    // Per unit: attempt answered
   input  wire logic [11:0] tx_ack_code,     // Per unit: acknowledge, 4 bits each
   output logic [2:0]       tx_retry,        // Per unit: resend pulse
   output logic [2:0]       tx_complete,     // Per unit: packet finished pulse
   output logic [11:0]      tx_status,       // Per unit: last acknowledge
   output logic [31:0]      manager_id,      // Bus manager id resource
   output logic [31:0]      bandwidth_avail, // Bandwidth available resource
   output logic [31:0]      chan_avail_hi,   // Channels available high resource
   output logic [31:0]      chan_avail_lo,   // Channels available low resource
   output logic             irq              // Level interrupt
);
   logic [31:0]         retry_r;
   logic [31:0]         new_value_r;
   logic [31:0]         expected_r;
   logic                done_r;
   logic [1:0]          select_r;
   logic [31:0]         resource_r [4];
   logic [rlc_pkg::IRQ_W-1:0] irq_status_r;
   logic [rlc_pkg::IRQ_W-1:0] irq_mask_r;
   logic                irq_r;
   rlc_pkg::rlc_cs_state_t cs_state_r;
   logic [1:0]          cs_sel_r;

   logic                dp_write_r;
   logic                dp_read_r;
   logic [7:0]          dp_addr_r;
   logic                hreadyout_r;
   logic [31:0]         hrdata_r;
   logic                addr_phase;
   logic                wr_en;
   logic [31:0]         rd_mux;
   logic [2:0]          exhausted;
   logic                cs_done_evt;

   function automatic logic hit(input logic [7:0] ofs);
      hit = wr_en && (dp_addr_r == ofs);
   endfunction : hit

   function automatic logic [3:0] unit_limit(input logic [31:0] r, input int unit);
      unit_limit = r[unit*rlc_pkg::RETRY_FIELD_W +: rlc_pkg::RETRY_FIELD_W];
   endfunction : unit_limit

   // Bus slave: a new address phase is taken only while the bus is ready
   always_comb begin
      addr_phase = hsel && hready && (htrans == rlc_pkg::HTRANS_NONSEQ || htrans == 2'h3);
      wr_en      = dp_write_r;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dp_write_r <= 1'b0;
         dp_read_r  <= 1'b0;
         dp_addr_r  <= 8'h00;
      end else if (hready) begin
         dp_write_r <= addr_phase && hwrite;
         dp_read_r  <= addr_phase && !hwrite;
         dp_addr_r  <= addr_phase ? {haddr[7:2], 2'h0} : dp_addr_r;
      end else begin
         dp_write_r <= 1'b0;
         dp_read_r  <= 1'b0;
      end
   end

   // Reads take one wait state so that a write just before is already visible
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout_r <= 1'b1;
         hrdata_r    <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         hreadyout_r <= 1'b0;
      end else if (!hreadyout_r) begin
         hreadyout_r <= 1'b1;
         hrdata_r    <= rd_mux;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (dp_addr_r)
         rlc_pkg::RETRY_OFS:      rd_mux = {20'h00000, retry_r[11:0]};
         rlc_pkg::NEW_VALUE_OFS:  rd_mux = new_value_r;
         rlc_pkg::EXPECTED_OFS:   rd_mux = expected_r;
         rlc_pkg::CONTROL_OFS:    rd_mux = {done_r, 29'h0000_0000, select_r};
         rlc_pkg::IRQ_STATUS_OFS: rd_mux = {28'h0000000, irq_status_r};
         rlc_pkg::IRQ_MASK_OFS:   rd_mux = {28'h0000000, irq_mask_r};
         rlc_pkg::RESOURCE_OFS:   rd_mux = resource_r[select_r];
         default:                 rd_mux = 32'h0000_0000;
      endcase
   end

   // Only the low twelve bits hold storage; the bounds above are never kept
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         retry_r <= rlc_pkg::RETRY_RESET;
      end else if (hit(rlc_pkg::RETRY_OFS)) begin
         retry_r <= {20'h00000, hwdata[11:0] & rlc_pkg::RETRY_RW_MASK};
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         new_value_r <= 32'h0000_0000;
         expected_r  <= 32'h0000_0000;
      end else begin
         if (hit(rlc_pkg::NEW_VALUE_OFS)) begin
            new_value_r <= hwdata;
         end
         if (hit(rlc_pkg::EXPECTED_OFS)) begin
            expected_r <= hwdata;
         end
      end
   end

   // Control write: clear done, latch the selector, launch the operation
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         select_r <= rlc_pkg::SELECT_RESET;
      end else if (hit(rlc_pkg::CONTROL_OFS)) begin
         select_r <= hwdata[1:0];
      end
   end

   // Completion wins over a clearing write in the same cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_r <= rlc_pkg::DONE_RESET;
      end else if (cs_done_evt) begin
         done_r <= 1'b1;
      end else if (hit(rlc_pkg::CONTROL_OFS)) begin
         done_r <= 1'b0;
      end
   end

   always_comb begin
      cs_done_evt = (cs_state_r == rlc_pkg::CS_SWAP);
   end

   // Two-step sequencer; a write while swapping queues a fresh operation
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_state_r <= rlc_pkg::CS_IDLE;
         cs_sel_r   <= rlc_pkg::SELECT_RESET;
      end else begin
         unique case (cs_state_r)
            rlc_pkg::CS_IDLE: begin
               if (hit(rlc_pkg::CONTROL_OFS)) begin
                  cs_state_r <= rlc_pkg::CS_SWAP;
                  cs_sel_r   <= hwdata[1:0];
               end
            end
            rlc_pkg::CS_SWAP: begin
               if (hit(rlc_pkg::CONTROL_OFS)) begin
                  cs_sel_r <= hwdata[1:0];
               end else begin
                  cs_state_r <= rlc_pkg::CS_IDLE;
               end
            end
            default: cs_state_r <= rlc_pkg::CS_IDLE;
         endcase
      end
   end

   // Compare and store in one edge, so no other update can slip between them
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         resource_r[rlc_pkg::SEL_MANAGER_ID] <= rlc_pkg::MANAGER_RESET;
         resource_r[rlc_pkg::SEL_BANDWIDTH]  <= rlc_pkg::BANDWIDTH_RESET;
         resource_r[rlc_pkg::SEL_CHAN_HI]    <= rlc_pkg::CHAN_RESET;
         resource_r[rlc_pkg::SEL_CHAN_LO]    <= rlc_pkg::CHAN_RESET;
      end else if (cs_state_r == rlc_pkg::CS_SWAP && resource_r[cs_sel_r] == expected_r) begin
         resource_r[cs_sel_r] <= new_value_r;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         manager_id      <= rlc_pkg::MANAGER_RESET;
         bandwidth_avail <= rlc_pkg::BANDWIDTH_RESET;
         chan_avail_hi   <= rlc_pkg::CHAN_RESET;
         chan_avail_lo   <= rlc_pkg::CHAN_RESET;
      end else begin
         manager_id      <= resource_r[rlc_pkg::SEL_MANAGER_ID];
         bandwidth_avail <= resource_r[rlc_pkg::SEL_BANDWIDTH];
         chan_avail_hi   <= resource_r[rlc_pkg::SEL_CHAN_HI];
         chan_avail_lo   <= resource_r[rlc_pkg::SEL_CHAN_LO];
      end
   end

   // Unit 0 request, 1 response, 2 physical response
   for (genvar u = 0; u < rlc_pkg::UNITS; u++) begin : g_unit
      rlc_retry_unit u_retry (
         .sys_clk     (sys_clk),
         .rst_n       (rst_n),
         .retry_limit (unit_limit(retry_r, u)),
         .ack_valid   (tx_ack_valid[u]),
         .ack_code    (tx_ack_code[u*4 +: 4]),
         .retry_r     (tx_retry[u]),
         .complete_r  (tx_complete[u]),
         .status_r    (tx_status[u*4 +: 4]),
         .exhausted_r (exhausted[u])
      );
   end

   // Sticky events: set wins over a write-one clear in the same cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status_r <= 4'h0;
      end else begin
         irq_status_r <= (irq_status_r & ~(hit(rlc_pkg::IRQ_STATUS_OFS) ? hwdata[3:0] : 4'h0))
                         | {exhausted, cs_done_evt};
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_r <= 4'h0;
      end else if (hit(rlc_pkg::IRQ_MASK_OFS)) begin
         irq_mask_r <= hwdata[3:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_status_r & irq_mask_r);
      end
   end

   always_comb begin
      hreadyout = hreadyout_r;
      hrdata    = hrdata_r;
      irq       = irq_r;
   end

   // Every answer is OKAY; an unmapped word reads zero and ignores writes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end
endmodule : rlc_top
`default_nettype wire

/* verif/rlc_top_chk.sv */
// Port-level checker of the retry and compare-swap slice
`timescale 1ns/10ps
`default_nettype none
module rlc_top_chk (
   input wire logic        sys_clk,      // Clock
   input wire logic        rst_n,        // Reset, active low
   input wire logic        hsel,         // Select
   input wire logic [31:0] haddr,        // Address
   input wire logic [1:0]  htrans,       // Transfer type
   input wire logic        hwrite,       // Write
   input wire logic [31:0] hwdata,       // Write data
   input wire logic        hready,       // Bus ready
   input wire logic        hreadyout,    // Slave ready
   input wire logic [31:0] hrdata,       // Read data
   input wire logic [2:0]  tx_ack_valid, // Ack strobes
   input wire logic [11:0] tx_ack_code,  // Ack codes
   input wire logic [2:0]  tx_retry,     // Resend pulses
   input wire logic [2:0]  tx_complete,  // Finish pulses
   input wire logic [11:0] tx_status,    // Last acks
   input wire logic [31:0] manager_id    // Resource 0
);
   logic        acc;
   logic        ctl_wr;
   logic        nv_wr_r;
   logic [31:0] nv_r;
   assign acc    = hsel && hready && htrans[1];
   assign ctl_wr = acc && hwrite && haddr[7:2] == 6'h05;
   // Shadow of the loaded new value, so a swap can be tied to what software wrote
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         nv_wr_r <= 1'b0;
         nv_r    <= 32'h0000_0000;
      end else begin
         nv_wr_r <= acc && hwrite && haddr[7:2] == 6'h03;
         if (nv_wr_r) nv_r <= hwdata;
      end
   end
   sequence rd_of(logic [5:0] w);
      acc && !hwrite && haddr[7:2] == w ##1 !hreadyout ##1 hreadyout;
   endsequence
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   second_bound_a: assert property (rd_of(6'h02) |-> hrdata[31:29] == 3'h0)
      else $error("second bound field reads nonzero");
   cycle_bound_a: assert property (rd_of(6'h02) |-> hrdata[28:16] == 13'h0)
      else $error("cycle bound field reads nonzero");
   retry_rsvd_a: assert property (rd_of(6'h02) |-> hrdata[15:12] == 4'h0)
      else $error("retry reserved bits read nonzero");
   ctl_rsvd_a: assert property (rd_of(6'h05) |-> hrdata[30:2] == 29'h0)
      else $error("control reserved bits read nonzero");
   req_pulse_a: assert property (tx_ack_valid[0] |=> tx_retry[0] ^ tx_complete[0])
      else $error("request unit gave no single answer to an ack");
   resp_cause_a: assert property (tx_retry[1] |-> $past(tx_ack_valid[1])
      && $past(tx_ack_code[7:4]) inside {4'h4, 4'h5, 4'h6, 4'hd})
      else $error("response unit resent without a busy ack");
   phys_clean_a: assert property (tx_ack_valid[2]
      && !(tx_ack_code[11:8] inside {4'h4, 4'h5, 4'h6, 4'hd}) |=> tx_complete[2] && !tx_retry[2])
      else $error("physical unit resent after a clean ack");
   status_last_a: assert property (tx_complete[1] |-> tx_status[7:4] == $past(tx_ack_code[7:4]))
      else $error("response status is not the last ack");
   swap_select_a: assert property ($changed(manager_id)
      |-> $past(ctl_wr, 4) && $past(hwdata[1:0], 3) == 2'h0)
      else $error("manager id changed without a swap on it");
   new_value_a: assert property ($changed(manager_id) |-> manager_id == nv_r)
      else $error("swap stored other than the new value");
endmodule : rlc_top_chk
bind rlc_top rlc_top_chk u_rlc_top_chk (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hreadyout, .hrdata, .tx_ack_valid, .tx_ack_code, .tx_retry,
   .tx_complete, .tx_status, .manager_id);
`default_nettype wire

/* verif/rlc_node_model.sv */
// Model of the remote nodes that acknowledge each transmit attempt
`timescale 1ns/10ps
`default_nettype none
module rlc_node_model (
   input  wire logic [0:0]  sys_clk,      // Clock
   input  wire logic        rst_n,        // Reset, active low
   input  wire logic [2:0]  start,        // Per unit: first attempt sent
   input  wire logic [2:0]  busy,         // Per unit: answer busy or error
   input  wire logic [3:0]  delay,        // Cycles to the ack, at least 1
   input  wire logic [2:0]  tx_retry,     // Per unit: attempt resent
   output logic      [2:0]  tx_ack_valid, // Per unit: ack strobe
   output logic      [11:0] tx_ack_code   // Per unit: ack code
);
   logic [3:0] wait_r [3];
   logic [1:0] pick_r [3];
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_ack_valid <= 3'h0;
         tx_ack_code  <= 12'h000;
         wait_r       <= '{4'h0, 4'h0, 4'h0};
         pick_r       <= '{2'h0, 2'h0, 2'h0};
      end else begin
         for (int u = 0; u < 3; u++) begin
            tx_ack_valid[u] <= 1'b0;
            // Code toggles between strobes so a stale value never looks like an answer
            tx_ack_code[4*u +: 4] <= ~tx_ack_code[4*u +: 4];
            if (start[u] || tx_retry[u]) begin
               wait_r[u] <= delay;
               if (start[u]) pick_r[u] <= 2'h0;
            end else if (wait_r[u] == 4'h1) begin
               wait_r[u]       <= 4'h0;
               pick_r[u]       <= pick_r[u] + 2'h1;
               tx_ack_valid[u] <= 1'b1;
               tx_ack_code[4*u +: 4] <= !busy[u] ? 4'h1 : pick_r[u] == 2'h0 ? 4'h4
                  : pick_r[u] == 2'h1 ? 4'h5 : pick_r[u] == 2'h2 ? 4'h6 : 4'hd;
            end else if (wait_r[u] != 4'h0) begin
               wait_r[u] <= wait_r[u] - 4'h1;
            end
         end
      end
   end
endmodule : rlc_node_model
`default_nettype wire

/* verif/tb.sv */
// Testbench: register map, retry limits, compare-swap and interrupts
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        sys_clk = 1'b0;
   logic        rst_n   = 1'b0;
   logic        hsel    = 1'b0;
   logic        hwrite  = 1'b0;
   logic [1:0]  htrans  = 2'h0;
   logic [31:0] haddr   = 32'h0;
   logic [31:0] hwdata  = 32'h0;
   logic [2:0]  start   = 3'h0;
   logic [2:0]  busy    = 3'h0;
   logic [3:0]  delay   = 4'h1;
   logic        hreadyout, hresp, irq;
   logic [31:0] hrdata, rd_d, mgr, bw, chi, clo;
   logic [2:0]  ack_v, retry, done_p;
   logic [11:0] ack_c, status;
   int          n_errors = 0;
   int          check_count = 0;
   int          nret [3] = '{0, 0, 0};
   rlc_top u_rlc_top (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tx_ack_valid(ack_v),
      .tx_ack_code(ack_c), .tx_retry(retry), .tx_complete(done_p), .tx_status(status),
      .manager_id(mgr), .bandwidth_avail(bw), .chan_avail_hi(chi), .chan_avail_lo(clo), .irq(irq));
   rlc_node_model u_rlc_node_model (.sys_clk(sys_clk), .rst_n(rst_n), .start(start), .busy(busy),
      .delay(delay), .tx_retry(retry), .tx_ack_valid(ack_v), .tx_ack_code(ack_c));
   initial forever #2.5 sys_clk = ~sys_clk;
   // Pulses are counted mid-cycle, away from the edge that launches them
   always @(negedge sys_clk) for (int u = 0; u < 3; u++) if (retry[u] === 1'b1) nret[u]++;
   // Ready is looked at before the edge, so the edge taken is the one that sees it high
   task automatic hold;
      for (int t = 0; t < 64; t++) begin
         @(negedge sys_clk);
         if (hreadyout === 1'b1) begin
            @(posedge sys_clk);
            break;
         end
      end
   endtask : hold
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      haddr  <= {24'h0, a};
      hwrite <= w;
      hsel   <= 1'b1;
      htrans <= rlc_pkg::HTRANS_NONSEQ;
      hold();
      htrans <= 2'h0;
      hwdata <= d;
      hold();
      rd_d = hrdata;
   endtask : xfer
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      chk(rd_d, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask : rchk
   task automatic give_verdict;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict
   task automatic run_unit(input int u, input logic b, input logic [3:0] dl);
      logic [3:0] lim;
      lim = u == 0 ? 4'h2 : u == 1 ? 4'h3 : 4'h1;
      busy[u] <= b;
      delay   <= dl;
      nret[u] = 0;
      start[u] <= 1'b1;
      @(posedge sys_clk);
      start[u] <= 1'b0;
      for (int t = 0; t < 200 && done_p[u] !== 1'b1; t++) @(negedge sys_clk);
      @(posedge sys_clk);
      chk(32'(nret[u]), b ? {28'h0, lim} : 32'h0);
      // Final code rotates 4,5,6,d per ack, so the last one follows from the limit
      chk({28'h0, status[4*u +: 4]}, !b ? 32'h1 : lim == 4'h1 ? 32'h5
         : lim == 4'h2 ? 32'h6 : 32'hd);
      rchk(8'h80, b ? 32'h1 << (u + 1) : 32'h0);
      chk({31'h0, irq}, {31'h0, b});
      xfer(8'h80, 1'b1, 32'he);
      repeat (2) @(posedge sys_clk);
      chk({31'h0, irq}, 32'h0);
   endtask : run_unit
   function automatic logic [31:0] rv(input logic [1:0] s);
      return s == 2'h0 ? rlc_pkg::MANAGER_RESET
         : s == 2'h1 ? rlc_pkg::BANDWIDTH_RESET : rlc_pkg::CHAN_RESET;
   endfunction : rv
   function automatic logic [31:0] port(input logic [1:0] s);
      return s == 2'h0 ? mgr : s == 2'h1 ? bw : s == 2'h2 ? chi : clo;
   endfunction : port
   task automatic swap(input logic [1:0] s);
      logic [31:0] nv;
      nv = 32'hc3a5_0000 | s;
      xfer(8'h84, 1'b1, {31'h0, s[0]});
      xfer(8'h0c, 1'b1, nv);
      xfer(8'h10, 1'b1, rv(s));
      xfer(8'h14, 1'b1, 32'h7fff_fffc | s);
      rchk(8'h14, 32'h8000_0000 | s);
      rchk(8'h88, nv);
      chk(port(s), nv);
      chk({31'h0, irq}, {31'h0, s[0]});
      xfer(8'h0c, 1'b1, 32'h0);
      xfer(8'h14, 1'b1, {30'h0, s});
      xfer(8'h80, 1'b1, 32'h1);
      rchk(8'h88, nv);
      chk({31'h0, irq}, 32'h0);
   endtask : swap
   initial begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rchk(8'h08, 32'h0);
      rchk(8'h14, 32'h8000_0000);
      rchk(8'h0c, 32'h0);
      rchk(8'h10, 32'h0);
      rchk(8'h88, rlc_pkg::MANAGER_RESET);
      rchk(8'h40, 32'h0);
      xfer(8'h40, 1'b1, 32'hffff_ffff);
      xfer(8'h08, 1'b1, 32'hffff_f132);
      rchk(8'h08, 32'h0000_0132);
      rchk(8'h40, 32'h0);
      $display("test registers done");
      xfer(8'h84, 1'b1, 32'he);
      for (int u = 0; u < 3; u++) begin
         for (int k = 0; k < 3; k++) run_unit(u, k != 2, k == 1 ? 4'h6 : 4'h1);
      end
      $display("test retries done");
      for (int s = 0; s < 4; s++) swap(s[1:0]);
      $display("test compare swap done");
      give_verdict();
   end
   initial begin
      #100000;
      n_errors++;
      give_verdict();
   end
endmodule : tb
`default_nettype wire
